// ==== logic/xls_lane_striper.v ====
// Notes on behaviour
// - A unit is a 16-bit protocol identifier then a 528-bit flit, no gap.
// - Units stripe over eight lanes, one byte per lane per symbol, lanes ascending.
// - Units start on lane 0 or lane 4; next identifier follows directly on lane 4.
// - Placement repeats every seventeen symbols; each direction keeps its own phase counter.
// - Latency optimized mode sends and expects no sync header.
// - Byte order: identifier low, identifier high, then flit bytes ascending.
// - Each flit carries its own identifier, so protocol classes interleave per flit.
`timescale 1ns/1ps
`include "xls_regs.vh"

// Small synchronous FIFO; ready and valid come from flops
module xls_fifo #(
  parameter WIDTH = `XLS_UNIT_W,
  parameter DEPTH = `XLS_FIFO_DEPTH,
  parameter AW    = `XLS_FIFO_AW
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             reset_n,
  input  wire             ce,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      cnt_r;
  reg [AW:0]      cnt_nxt;
  reg             in_ready_r;
  reg             out_valid_r;
  wire            push;
  wire            pop;

  assign push      = in_valid & in_ready_r;
  assign pop       = out_valid_r & out_ready;
  assign in_ready  = in_ready_r;
  assign out_valid = out_valid_r;
  assign out_data  = mem_r[rd_ptr_r];

  // Occupancy after this cycle's push and pop
  always @* begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // Pointers wrap at DEPTH so depth need not be a power of two
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_r    <= {AW{1'b0}};
      rd_ptr_r    <= {AW{1'b0}};
      cnt_r       <= {(AW+1){1'b0}};
      in_ready_r  <= 1'b0;
      out_valid_r <= 1'b0;
    end else if (ce) begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      end
      cnt_r       <= cnt_nxt;
      in_ready_r  <= (cnt_nxt != DEPTH);
      out_valid_r <= (cnt_nxt != {(AW+1){1'b0}});
    end
  end

  // Storage has no reset; contents are only read behind out_valid
  always @(posedge mclk) begin
    if (ce && push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

endmodule // xls_fifo

// Eight-lane striper and destriper
module xls_lane_striper #(
  parameter FIFO_DEPTH = `XLS_FIFO_DEPTH,
  parameter FIFO_AW    = `XLS_FIFO_AW
) (
  // Clock, reset, enable
  input  wire                   mclk,
  input  wire                   reset_n,
  input  wire                   ce,
  // Mode
  input  wire                   lat_opt,
  // Transmit unit source
  input  wire                   tx_in_valid,
  output wire                   tx_in_ready,
  input  wire [`XLS_PID_W-1:0]  tx_in_protocol_identifier,
  input  wire [`XLS_FLIT_W-1:0] tx_in_flit,
  // Transmit lanes
  output reg  [`XLS_BUS_W-1:0]  tx_lane_data,
  output reg                    tx_lane_valid,
  output reg  [1:0]             tx_sync_hdr,
  output reg                    tx_sync_valid,
  // Receive lanes
  input  wire [`XLS_BUS_W-1:0]  rx_lane_data,
  input  wire                   rx_lane_valid,
  input  wire [1:0]             rx_sync_hdr,
  input  wire                   rx_sync_valid,
  // Receive unit sink
  output reg                    rx_unit_valid,
  output reg  [`XLS_PID_W-1:0]  rx_protocol_identifier,
  output reg  [`XLS_FLIT_W-1:0] rx_flit,
  output reg                    rx_sync_err
);

  // Byte k of a unit; identifier bytes sit lowest, so they go first
  function [7:0] unit_byte;
    input [`XLS_UNIT_W-1:0] u;
    input [6:0]             k;
    begin
      unit_byte = u[k * `XLS_LANE_W +: 8];
    end
  endfunction

  // Stream position of lane l in phase p within the two-unit pattern
  function [7:0] stream_pos;
    input [`XLS_PHASE_W-1:0] p;
    input [3:0]              l;
    begin
      stream_pos = {p, 3'h0} + {4'h0, l};
    end
  endfunction

  // ---------------- Transmit ----------------
  wire                   f_valid;
  wire [`XLS_UNIT_W-1:0] f_data;
  reg                    f_pop;
  reg [`XLS_UNIT_W-1:0]  tx_a_r;
  reg [`XLS_UNIT_W-1:0]  tx_b_r;
  reg [`XLS_PHASE_W-1:0] tx_phase_r;
  reg [`XLS_BLOCK_W-1:0] tx_blk_r;
  reg                    tx_hdr_sent_r;
  reg [`XLS_BUS_W-1:0]   tx_lanes_nxt;
  reg                    need_unit;
  reg                    hdr_due;
  reg                    emit;
  reg [7:0]              g;
  integer                l;

  // Identifier below flit forms one unit with no gap between them
  xls_fifo #(
    .WIDTH (`XLS_UNIT_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_tx_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .ce        (ce),
    .in_valid  (tx_in_valid),
    .in_ready  (tx_in_ready),
    .in_data   ({tx_in_flit, tx_in_protocol_identifier}),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  // Lane bytes for this phase; phases 0 and 8 take a fresh unit straight from the FIFO
  always @* begin
    g            = 8'h00;
    tx_lanes_nxt = {`XLS_BUS_W{1'b0}};
    need_unit    = (tx_phase_r == {`XLS_PHASE_W{1'b0}}) || (tx_phase_r == `XLS_PHASE_MID);
    hdr_due      = !lat_opt && (tx_blk_r == {`XLS_BLOCK_W{1'b0}}) && !tx_hdr_sent_r;
    emit         = !hdr_due && (!need_unit || f_valid);
    f_pop        = ce && emit && need_unit;
    for (l = 0; l < `XLS_LANES; l = l + 1) begin
      g = stream_pos(tx_phase_r, l[3:0]);
      if (g < {1'b0, `XLS_UNIT_BYTES}) begin
        // First unit of the pair, starting on lane 0
        tx_lanes_nxt[l*`XLS_LANE_W +: 8] = unit_byte(
          (tx_phase_r == {`XLS_PHASE_W{1'b0}}) ? f_data : tx_a_r, g[6:0]);
      end else begin
        // Second unit starts on lane 4 right after the first ends on lane 3
        g = g - {1'b0, `XLS_UNIT_BYTES};
        tx_lanes_nxt[l*`XLS_LANE_W +: 8] = unit_byte(
          (tx_phase_r == `XLS_PHASE_MID) ? f_data : tx_b_r, g[6:0]);
      end
    end
  end

  // Symbol sequencing; a missing unit stalls the pattern rather than breaking it
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_a_r        <= {`XLS_UNIT_W{1'b0}};
      tx_b_r        <= {`XLS_UNIT_W{1'b0}};
      tx_phase_r    <= {`XLS_PHASE_W{1'b0}};
      tx_blk_r      <= {`XLS_BLOCK_W{1'b0}};
      tx_hdr_sent_r <= 1'b0;
      tx_lane_data  <= {`XLS_BUS_W{1'b0}};
      tx_lane_valid <= 1'b0;
      tx_sync_hdr   <= 2'h0;
      tx_sync_valid <= 1'b0;
    end else if (ce) begin
      tx_sync_valid <= 1'b0;
      tx_lane_valid <= 1'b0;
      if (hdr_due) begin
        // Header symbol: 0 then 1 on every lane, striping position untouched
        tx_sync_hdr   <= `XLS_SYNC_DATA;
        tx_sync_valid <= 1'b1;
        tx_hdr_sent_r <= 1'b1;
      end else if (emit) begin
        tx_lane_data  <= tx_lanes_nxt;
        tx_lane_valid <= 1'b1;
        if (tx_phase_r == {`XLS_PHASE_W{1'b0}}) begin
          tx_a_r <= f_data;
        end
        if (tx_phase_r == `XLS_PHASE_MID) begin
          tx_b_r <= f_data;
        end
        tx_phase_r <= (tx_phase_r == `XLS_PHASE_LAST) ?
                      {`XLS_PHASE_W{1'b0}} : tx_phase_r + 1'b1;
        // Block count only matters while headers are in use
        if (!lat_opt) begin
          tx_blk_r <= tx_blk_r + 1'b1;
          if (tx_blk_r == `XLS_BLOCK_LAST) begin
            tx_hdr_sent_r <= 1'b0;
          end
        end
      end
    end
  end

  // ---------------- Receive ----------------
  reg [`XLS_UNIT_W-1:0]  rx_a_r;
  reg [`XLS_UNIT_W-1:0]  rx_b_r;
  reg [`XLS_UNIT_W-1:0]  rx_a_nxt;
  reg [`XLS_UNIT_W-1:0]  rx_b_nxt;
  reg [`XLS_PHASE_W-1:0] rx_phase_r;
  reg                    rx_is_data;
  reg [7:0]              h;
  integer                m;

  // A header symbol is only honoured with headers on; otherwise every symbol is data
  always @* begin
    rx_is_data = rx_lane_valid && !(rx_sync_valid && !lat_opt);
    rx_a_nxt   = rx_a_r;
    rx_b_nxt   = rx_b_r;
    h          = 8'h00;
    for (m = 0; m < `XLS_LANES; m = m + 1) begin
      h = stream_pos(rx_phase_r, m[3:0]);
      if (h < {1'b0, `XLS_UNIT_BYTES}) begin
        rx_a_nxt[h[6:0] * `XLS_LANE_W +: 8] = rx_lane_data[m*`XLS_LANE_W +: 8];
      end else begin
        h = h - {1'b0, `XLS_UNIT_BYTES};
        rx_b_nxt[h[6:0] * `XLS_LANE_W +: 8] = rx_lane_data[m*`XLS_LANE_W +: 8];
      end
    end
  end

  // Destripe with the same seventeen-symbol phase; units complete after phases 8 and 16
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_a_r                 <= {`XLS_UNIT_W{1'b0}};
      rx_b_r                 <= {`XLS_UNIT_W{1'b0}};
      rx_phase_r             <= {`XLS_PHASE_W{1'b0}};
      rx_unit_valid          <= 1'b0;
      rx_protocol_identifier <= {`XLS_PID_W{1'b0}};
      rx_flit                <= {`XLS_FLIT_W{1'b0}};
      rx_sync_err            <= 1'b0;
    end else if (ce) begin
      rx_unit_valid <= 1'b0;
      // Sticky; only reset clears it since nothing else can acknowledge it
      if (rx_lane_valid && rx_sync_valid && !lat_opt &&
          rx_sync_hdr != `XLS_SYNC_DATA) begin
        rx_sync_err <= 1'b1;
      end
      if (rx_is_data) begin
        rx_a_r     <= rx_a_nxt;
        rx_b_r     <= rx_b_nxt;
        rx_phase_r <= (rx_phase_r == `XLS_PHASE_LAST) ?
                      {`XLS_PHASE_W{1'b0}} : rx_phase_r + 1'b1;
        if (rx_phase_r == `XLS_PHASE_MID) begin
          rx_unit_valid          <= 1'b1;
          rx_protocol_identifier <= rx_a_nxt[`XLS_PID_W-1:0];
          rx_flit                <= rx_a_nxt[`XLS_UNIT_W-1:`XLS_PID_W];
        end else if (rx_phase_r == `XLS_PHASE_LAST) begin
          rx_unit_valid          <= 1'b1;
          rx_protocol_identifier <= rx_b_nxt[`XLS_PID_W-1:0];
          rx_flit                <= rx_b_nxt[`XLS_UNIT_W-1:`XLS_PID_W];
        end
      end
    end
  end

endmodule // xls_lane_striper

// ==== logic/xls_regs.vh ====
`ifndef XLS_REGS_VH
`define XLS_REGS_VH

// Link geometry
`define XLS_LANES        8
`define XLS_LANE_W       8
`define XLS_BUS_W        64
`define XLS_PID_W        16
`define XLS_FLIT_W       528
`define XLS_UNIT_W       544
`define XLS_UNIT_BYTES   7'h44

// Striping pattern: two units fill exactly seventeen symbols
`define XLS_PHASE_LAST   5'h10
`define XLS_PHASE_MID    5'h08
`define XLS_PHASE_W      5

// Sync header framing
`define XLS_BLOCK_LAST   4'hF
`define XLS_BLOCK_W      4
`define XLS_SYNC_DATA    2'h2

// Transmit buffer
`define XLS_FIFO_DEPTH   4
`define XLS_FIFO_AW      2

`endif

// ==== verification/xls_chk_assertions.sv ====
`timescale 1ns/1ps
// Port watcher for the striper
module xls_chk (
  // Clock and mode
  input wire        mclk,
  input wire        reset_n,
  input wire        ce,
  input wire        lat_opt,
  // Lanes
  input wire        tx_lane_valid,
  input wire        tx_sync_valid,
  input wire [1:0]  tx_sync_hdr,
  input wire        rx_lane_valid,
  input wire        rx_sync_valid,
  input wire [1:0]  rx_sync_hdr,
  // Units
  input wire        rx_unit_valid,
  input wire [15:0] rx_protocol_identifier,
  input wire        rx_sync_err
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // A symbol slot is data or header, never both
  a_slot_excl: assert property (!(tx_lane_valid && tx_sync_valid))
    else $error("data and header together");
  a_hdr_value: assert property (tx_sync_valid |-> tx_sync_hdr == 2'h2)
    else $error("bad header value");
  a_hdr_none: assert property (lat_opt && $past(lat_opt) |-> !tx_sync_valid)
    else $error("header in low latency mode");
  // No header in the eight cycles after a header
  a_hdr_gap: assert property (tx_sync_valid |=> !tx_sync_valid [*8])
    else $error("headers too close");
  // Units end at phases 8 and 16, so at least eight symbols apart
  a_unit_gap: assert property (rx_unit_valid |=> !rx_unit_valid [*7])
    else $error("unit pulses too close");
  a_unit_hold: assert property (!rx_unit_valid |-> $stable(rx_protocol_identifier))
    else $error("identifier moved without unit");
  a_err_stick: assert property (rx_sync_err |=> rx_sync_err)
    else $error("sync error cleared");
  a_err_cause: assert property ($rose(rx_sync_err) |-> $past(ce && rx_lane_valid &&
    rx_sync_valid && !lat_opt && rx_sync_hdr != 2'h2))
    else $error("sync error without bad header");
endmodule // xls_chk

bind xls_lane_striper xls_chk u_chk (.mclk, .reset_n, .ce, .lat_opt, .tx_lane_valid,
  .tx_sync_valid, .tx_sync_hdr, .rx_lane_valid, .rx_sync_valid, .rx_sync_hdr,
  .rx_unit_valid, .rx_protocol_identifier, .rx_sync_err);

// ==== verification/xls_lane_striper_tb_top.sv ====
`timescale 1ns/1ps
`include "xls_regs.vh"
// Loops the lanes through the peer; checks lane symbols and units
module xls_lane_striper_tb_top;
  reg         mclk = 1'b0;
  reg         reset_n = 1'b0;
  reg         ce = 1'b1;
  reg         lat_opt = 1'b1;
  reg         bad_hdr = 1'b0;
  reg         tx_in_valid = 1'b0;
  reg [15:0]  tx_in_protocol_identifier = 16'h0;
  reg [527:0] tx_in_flit = 528'h0;
  reg         refused = 1'b0;
  reg [63:0]  sym [0:127];
  reg [543:0] rq [$];
  wire [63:0] tx_lane_data, rx_lane_data;
  wire [1:0]  tx_sync_hdr, rx_sync_hdr;
  wire        tx_in_ready, tx_lane_valid, tx_sync_valid, rx_lane_valid, rx_sync_valid;
  wire        rx_unit_valid, rx_sync_err;
  wire [15:0] rx_protocol_identifier;
  wire [527:0] rx_flit;
  integer     num_errors = 0;
  integer     n_compared = 0;
  integer     nsym = 0;
  integer     hq [$];

  always #4 mclk = ~mclk;

  xls_lane_striper dut (.mclk, .reset_n, .ce, .lat_opt, .tx_in_valid, .tx_in_ready,
    .tx_in_protocol_identifier, .tx_in_flit, .tx_lane_data, .tx_lane_valid, .tx_sync_hdr,
    .tx_sync_valid, .rx_lane_data, .rx_lane_valid, .rx_sync_hdr, .rx_sync_valid,
    .rx_unit_valid, .rx_protocol_identifier, .rx_flit, .rx_sync_err);
  xls_peer peer (.mclk, .bad_hdr, .tx_lane_data, .tx_lane_valid, .tx_sync_hdr,
    .tx_sync_valid, .rx_lane_data, .rx_lane_valid, .rx_sync_hdr, .rx_sync_valid);

  // Log data symbols, header positions, units and refusals
  always @(posedge mclk) begin
    if (!reset_n) begin
      nsym = 0;
      rq.delete();
      hq.delete();
      refused = 1'b0;
    end else begin
      if (tx_sync_valid === 1'b1) hq.push_back(nsym);
      if (tx_lane_valid === 1'b1) begin
        sym[nsym] = tx_lane_data;
        nsym = nsym + 1;
      end
      if (rx_unit_valid === 1'b1) rq.push_back({rx_flit, rx_protocol_identifier});
      if (tx_in_valid && tx_in_ready === 1'b0) refused = 1'b1;
    end
  end

  // Unit i: distinct bytes so any misplaced byte shows
  function [543:0] mk(input integer i);
    integer b;
    for (b = 0; b < 68; b = b + 1) mk[8*b +: 8] = 8'(b * 3 + i * 29);
  endfunction

  task cmp(input string what, input [543:0] exp, input [543:0] got);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("[ERR] %0s exp %0h got %0h", what, exp, got);
    end
  endtask

  task end_sim;
    if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Reset starts off the edge; one edge after release lets the buffer report room
  task do_reset(input m);
    @(posedge mclk) #1;
    reset_n = 1'b0;
    lat_opt = m;
    repeat (5) @(posedge mclk);
    #1 reset_n = 1'b1;
    @(posedge mclk) #1;
  endtask

  // Offer units back to back; a refused offer is held
  task send(input integer n);
    integer i, w;
    for (i = 0; i < n; i = i + 1) begin
      {tx_in_flit, tx_in_protocol_identifier} = mk(i);
      tx_in_valid = 1'b1;
      for (w = 0; w < 300 && tx_in_ready !== 1'b1; w = w + 1) @(posedge mclk) #1;
      @(posedge mclk) #1;
    end
    tx_in_valid = 1'b0;
  endtask

  // Pairs fill seventeen symbols; headers lead every sixteen data symbols
  task check(input integer n);
    integer i, p, w;
    reg [1087:0] pair;
    for (w = 0; w < 900 && rq.size() < n; w = w + 1) @(posedge mclk) #1;
    cmp("units", n, rq.size());
    cmp("symbols", 17 * n / 2, nsym);
    for (i = 0; i < rq.size(); i = i + 1) cmp("unit", mk(i), rq[i]);
    for (i = 0; i < n; i = i + 2) begin
      pair = {mk(i + 1), mk(i)};
      for (p = 0; p < 17; p = p + 1) cmp("symbol", pair[64*p +: 64], sym[17*(i/2)+p]);
    end
    cmp("headers", lat_opt ? 0 : (17 * n / 2 + 15) / 16, hq.size());
    for (i = 0; i < hq.size(); i = i + 1) cmp("hdr pos", 16 * i, hq[i]);
  endtask

  task s_stripe_pair;
    do_reset(1'b1);
    send(2);
    check(2);
  endtask

  // With the enable low an offer must not be taken and no symbol may leave
  task s_ce_freeze;
    do_reset(1'b1);
    ce = 1'b0;
    {tx_in_flit, tx_in_protocol_identifier} = mk(0);
    tx_in_valid = 1'b1;
    repeat (10) @(posedge mclk) #1;
    tx_in_valid = 1'b0;
    cmp("frozen lanes", 0, nsym);
    cmp("frozen units", 0, rq.size());
    ce = 1'b1;
    send(2);
    check(2);
  endtask

  // Eight units overrun the four-word buffer while headers interleave
  task s_sync_fill;
    do_reset(1'b0);
    send(8);
    cmp("refused", 1, refused);
    check(8);
    cmp("sync err", 0, rx_sync_err);
  endtask

  task s_bad_hdr;
    do_reset(1'b0);
    bad_hdr = 1'b1;
    send(2);
    check(2);
    cmp("sync err", 1, rx_sync_err);
  endtask

  initial begin
    #1;
    s_stripe_pair;
    s_ce_freeze;
    s_sync_fill;
    s_bad_hdr;
    end_sim;
  end

  // Watchdog: the scenarios need about two hundred cycles
  initial begin
    #50000;
    num_errors = num_errors + 1;
    end_sim;
  end
endmodule // xls_lane_striper_tb_top

// ==== verification/xls_peer.sv ====
`timescale 1ns/1ps
// Peer port: returns our lanes one symbol later
module xls_peer (
  // Clock and fault control
  input wire        mclk,
  input wire        bad_hdr,
  // From the striper
  input wire [63:0] tx_lane_data,
  input wire        tx_lane_valid,
  input wire [1:0]  tx_sync_hdr,
  input wire        tx_sync_valid,
  // To the destriper
  output reg [63:0] rx_lane_data = 64'h0,
  output reg        rx_lane_valid = 1'b0,
  output reg [1:0]  rx_sync_hdr = 2'h0,
  output reg        rx_sync_valid = 1'b0
);
  // Idle lines invert so a stale symbol never looks fresh
  always @(posedge mclk) begin
    rx_lane_valid <= tx_lane_valid | tx_sync_valid;
    rx_sync_valid <= tx_sync_valid;
    rx_lane_data  <= tx_lane_valid ? tx_lane_data : ~rx_lane_data;
    rx_sync_hdr   <= tx_sync_valid ? (bad_hdr ? 2'h1 : tx_sync_hdr) : ~rx_sync_hdr;
  end
endmodule // xls_peer
